// ---- hdl/hpv_top.sv ----
// Headphone output volume control: registers, pump mode, mixer and slewing
module hpv_top #(
	parameter int unsigned ZC_TIMEOUT_CYC = hpv_pkg::ZC_TIMEOUT_CYC,
	parameter int unsigned SLEW_STEP_CYC = hpv_pkg::SLEW_STEP_CYC
) (
	input wire logic clk_sys, // System clock
	input wire logic sys_rst, // Async reset, high
	input wire logic [7:0] reg_addr, // Register offset
	input wire logic reg_wr, // Write strobe
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_rd, // Read strobe
	output logic [7:0] reg_rdata, // Read data, next cycle
	input wire logic [7:0] pump_signal_level, // Signal level vs rail
	input wire logic pump_dynamic_off, // Fixed pump mode
	input wire logic pump_force_full, // Fixed mode rail choice
	input wire logic [1:0] zero_cross_in, // Crossings, [1] right
	input wire logic [1:0] phone_enable_req, // Channel on, [1] right
	input wire logic recv_amp_req, // Receiver amp wanted
	input wire logic left_spk_amp_req, // Left speaker amp wanted
	output logic pump_fast_rate, // High switching rate
	output logic pump_full_rail, // Full rail output
	output logic [7:0] left_phone_mixer_select, // Left sources
	output logic [7:0] right_phone_mixer_select, // Right sources
	output logic left_phone_path_choice, // 1 = via mixer
	output logic right_phone_path_choice, // 1 = via mixer
	output logic [3:0] left_mixer_attenuation, // Loss in dB
	output logic [3:0] right_mixer_attenuation, // Loss in dB
	output logic left_phone_mute, // Left mute
	output logic right_phone_mute, // Right mute
	output logic [4:0] left_phone_volume, // Applied left code
	output logic [4:0] right_phone_volume, // Applied right code
	output logic [7:0] left_phone_gain_half_db, // Signed gain, 0.5 dB
	output logic [7:0] right_phone_gain_half_db, // Signed gain, 0.5 dB
	output logic [1:0] phone_amp_on, // Amp enables, [1] right
	output logic receiver_pin_short, // Receiver pin switch
	output logic receiver_to_speaker_switch, // Receiver to speaker
	output logic receiver_amp_enable, // Gated receiver amp
	output logic left_speaker_amp_enable, // Gated speaker amp
	output logic zero_cross_enable, // Gating for all arrays
	output logic slew_enable, // Slewing for other volumes
	output logic enhanced_slew_enable, // Enhanced slewing
	output logic [3:0] distortion_limit_level, // Limiter threshold
	output logic [3:0] distortion_release_time // Limiter release
);

	////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [7:0] mix_l;
		logic [7:0] mix_r;
		logic [7:0] path;
		logic [7:0] lvl_l;
		logic [7:0] lvl_r;
		logic [7:0] clip;
		logic [7:0] smooth;
		logic [7:0] bypass;
		logic slew_done;
		logic busy_prev;
		logic [7:0] rdata;
		logic [1:0] zc_meta;
		logic [1:0] zc_sync;
		logic [7:0] lvl_meta;
		logic [7:0] lvl_sync;
		logic pump_fast;
		logic pump_full;
		logic [7:0] gain_l;
		logic [7:0] gain_r;
		logic [3:0] att_l;
		logic [3:0] att_r;
		logic recv_amp;
		logic spk_amp;
		logic [2:0] en;
	} hpv_top_state_type;

	hpv_top_state_type s_r;
	hpv_top_state_type s_nxt;

	logic [1:0] ch_busy;
	logic [1:0][4:0] ch_vol;
	logic [1:0][4:0] ch_target;
	logic any_busy;

	////////////////////////////////////////////////////////////////////////////
	// Decoders used by both channels

	function automatic logic [3:0] atten_db(input logic [1:0] code);
		logic [3:0] db;
		db = 4'h0;
		unique case (code)
			2'b00: db = 4'h0;
			2'b01: db = 4'h6;
			2'b10: db = 4'h9;
			2'b11: db = 4'hc;
		endcase
		return db;
	endfunction : atten_db

	// Gain in half-dB steps, two's complement
	function automatic logic [7:0] gain_half_db(input logic [4:0] code);
		logic [7:0] g;
		g = 8'h00;
		unique case (code)
			5'h00: g = 8'h7a;
			5'h01: g = 8'h82;
			5'h02: g = 8'h8a;
			5'h03: g = 8'h92;
			5'h04: g = 8'h9a;
			5'h05: g = 8'ha2;
			5'h06: g = 8'haa;
			5'h07: g = 8'hb0;
			5'h08: g = 8'hb6;
			5'h09: g = 8'hbc;
			5'h0a: g = 8'hc2;
			5'h0b: g = 8'hc8;
			5'h0c: g = 8'hce;
			5'h0d: g = 8'hd4;
			5'h0e: g = 8'hda;
			5'h0f: g = 8'hde;
			5'h10: g = 8'he2;
			5'h11: g = 8'he6;
			5'h12: g = 8'hea;
			5'h13: g = 8'hee;
			5'h14: g = 8'hf2;
			5'h15: g = 8'hf6;
			5'h16: g = 8'hf8;
			5'h17: g = 8'hfa;
			5'h18: g = 8'hfc;
			5'h19: g = 8'hfe;
			5'h1a: g = 8'h00;
			5'h1b: g = 8'h02;
			5'h1c: g = 8'h03;
			5'h1d: g = 8'h04;
			5'h1e: g = 8'h05;
			5'h1f: g = 8'h06;
		endcase
		return g;
	endfunction : gain_half_db

	////////////////////////////////////////////////////////////////////////////
	// Channel sequencers

	assign ch_target[0] = s_r.lvl_l[hpv_pkg::VOL_W-1:0];
	assign ch_target[1] = s_r.lvl_r[hpv_pkg::VOL_W-1:0];

	generate
		for (genvar ch = 0; ch < 2; ch++) begin : g_chan
			hpv_chan_slew #(
				.TIMEOUT_CYC(ZC_TIMEOUT_CYC),
				.STEP_CYC(SLEW_STEP_CYC)
			) u_slew (
				.clk_sys(clk_sys),
				.sys_rst(sys_rst),
				.enable_req(phone_enable_req[ch]),
				.target(ch_target[ch]),
				.slew_on(!s_r.smooth[hpv_pkg::BIT_SLEW_OFF]),
				.enh_on(!s_r.smooth[hpv_pkg::BIT_ENH_SLEW_OFF]),
				.zc_on(!s_r.smooth[hpv_pkg::BIT_ZC_OFF]),
				.zero_cross(s_r.zc_sync[ch]),
				.vol_applied(ch_vol[ch]),
				.amp_on(phone_amp_on[ch]),
				.busy(ch_busy[ch])
			);
		end
	endgenerate

	assign any_busy = |ch_busy;

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_nxt = s_r;

		// Async pins pass two flops before use
		s_nxt.zc_meta = zero_cross_in;
		s_nxt.zc_sync = s_r.zc_meta;
		s_nxt.lvl_meta = pump_signal_level;
		s_nxt.lvl_sync = s_r.lvl_meta;

		if (reg_wr) begin
			case (reg_addr)
				hpv_pkg::ADDR_LEFT_MIX: s_nxt.mix_l = reg_wdata;
				hpv_pkg::ADDR_RIGHT_MIX: s_nxt.mix_r = reg_wdata;
				hpv_pkg::ADDR_MIX_PATH: s_nxt.path = reg_wdata;
				hpv_pkg::ADDR_LEFT_LEVEL: s_nxt.lvl_l = reg_wdata;
				hpv_pkg::ADDR_RIGHT_LEVEL: s_nxt.lvl_r = reg_wdata;
				hpv_pkg::ADDR_CLIP: s_nxt.clip = reg_wdata;
				hpv_pkg::ADDR_SMOOTH: s_nxt.smooth = reg_wdata;
				hpv_pkg::ADDR_BYPASS: s_nxt.bypass = reg_wdata;
				default: ;
			endcase
		end

		if (reg_rd) begin
			case (reg_addr)
				hpv_pkg::ADDR_STATUS: s_nxt.rdata = 8'(s_r.slew_done) << hpv_pkg::BIT_SLEW_DONE;
				hpv_pkg::ADDR_LEFT_MIX: s_nxt.rdata = s_r.mix_l;
				hpv_pkg::ADDR_RIGHT_MIX: s_nxt.rdata = s_r.mix_r;
				hpv_pkg::ADDR_MIX_PATH: s_nxt.rdata = s_r.path;
				hpv_pkg::ADDR_LEFT_LEVEL: s_nxt.rdata = s_r.lvl_l;
				hpv_pkg::ADDR_RIGHT_LEVEL: s_nxt.rdata = s_r.lvl_r;
				hpv_pkg::ADDR_CLIP: s_nxt.rdata = s_r.clip;
				hpv_pkg::ADDR_SMOOTH: s_nxt.rdata = s_r.smooth;
				hpv_pkg::ADDR_BYPASS: s_nxt.rdata = s_r.bypass;
				default: s_nxt.rdata = 8'h00;
			endcase
		end

		// Falling any-busy means the last of the channels just finished; set beats read-clear
		if (reg_rd && reg_addr == hpv_pkg::ADDR_STATUS) begin
			s_nxt.slew_done = 1'b0;
		end
		if (s_r.busy_prev && !any_busy) begin
			s_nxt.slew_done = 1'b1;
		end
		s_nxt.busy_prev = any_busy;

		// Forced mode keeps the fast rate so the fixed rail can carry full load
		if (pump_dynamic_off) begin
			s_nxt.pump_fast = 1'b1;
			s_nxt.pump_full = pump_force_full;
		end else begin
			s_nxt.pump_fast = (s_r.lvl_sync > hpv_pkg::THR_LOW_RATE);
			s_nxt.pump_full = (s_r.lvl_sync > hpv_pkg::THR_HALF_RAIL);
		end

		s_nxt.att_l = atten_db(s_r.path[hpv_pkg::LEFT_ATT_LSB+:2]);
		s_nxt.att_r = atten_db(s_r.path[hpv_pkg::RIGHT_ATT_LSB+:2]);
		s_nxt.gain_l = gain_half_db(ch_vol[0]);
		s_nxt.gain_r = gain_half_db(ch_vol[1]);

		// Amps are held off while their bypass switch is closed, even if asked
		s_nxt.recv_amp = recv_amp_req && !s_r.bypass[hpv_pkg::BIT_RECV_SHORT];
		s_nxt.spk_amp = left_spk_amp_req && !s_r.bypass[hpv_pkg::BIT_RECV_TO_SPK];
		// Taken from the next value so the enable pins keep the register's timing
		s_nxt.en = ~s_nxt.smooth[hpv_pkg::BIT_ZC_OFF+:3];
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '0;
			s_r.mix_l <= hpv_pkg::RST_REG;
			s_r.mix_r <= hpv_pkg::RST_REG;
			s_r.path <= hpv_pkg::RST_REG;
			s_r.lvl_l <= hpv_pkg::RST_REG;
			s_r.lvl_r <= hpv_pkg::RST_REG;
			s_r.clip <= hpv_pkg::RST_REG;
			s_r.smooth <= hpv_pkg::RST_REG;
			s_r.bypass <= hpv_pkg::RST_REG;
			s_r.en <= ~hpv_pkg::RST_REG[hpv_pkg::BIT_ZC_OFF+:3];
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all from flops

	assign reg_rdata = s_r.rdata;
	assign pump_fast_rate = s_r.pump_fast;
	assign pump_full_rail = s_r.pump_full;
	assign left_phone_mixer_select = s_r.mix_l;
	assign right_phone_mixer_select = s_r.mix_r;
	assign left_phone_path_choice = s_r.path[hpv_pkg::BIT_LEFT_PATH];
	assign right_phone_path_choice = s_r.path[hpv_pkg::BIT_RIGHT_PATH];
	assign left_mixer_attenuation = s_r.att_l;
	assign right_mixer_attenuation = s_r.att_r;
	assign left_phone_mute = s_r.lvl_l[hpv_pkg::BIT_MUTE];
	assign right_phone_mute = s_r.lvl_r[hpv_pkg::BIT_MUTE];
	assign left_phone_volume = ch_vol[0];
	assign right_phone_volume = ch_vol[1];
	assign left_phone_gain_half_db = s_r.gain_l;
	assign right_phone_gain_half_db = s_r.gain_r;
	assign receiver_pin_short = s_r.bypass[hpv_pkg::BIT_RECV_SHORT];
	assign receiver_to_speaker_switch = s_r.bypass[hpv_pkg::BIT_RECV_TO_SPK];
	assign receiver_amp_enable = s_r.recv_amp;
	assign left_speaker_amp_enable = s_r.spk_amp;
	assign zero_cross_enable = s_r.en[0];
	assign slew_enable = s_r.en[1];
	assign enhanced_slew_enable = s_r.en[2];
	assign distortion_limit_level = s_r.clip[hpv_pkg::LIMIT_LSB+:4];
	assign distortion_release_time = s_r.clip[hpv_pkg::RELEASE_W-1:0];

endmodule : hpv_top

// ---- hdl/hpv_pkg.sv ----
// Shared constants and types for the headphone output volume control block
package hpv_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned ZC_TIMEOUT_MS = 100;
	localparam int unsigned ZC_TIMEOUT_CYC = CLK_HZ / 1000 * ZC_TIMEOUT_MS;
	localparam int unsigned SLEW_STEP_CYC = 64;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_LEFT_MIX = 8'h25;
	localparam logic [7:0] ADDR_RIGHT_MIX = 8'h26;
	localparam logic [7:0] ADDR_MIX_PATH = 8'h27;
	localparam logic [7:0] ADDR_LEFT_LEVEL = 8'h39;
	localparam logic [7:0] ADDR_RIGHT_LEVEL = 8'h3a;
	localparam logic [7:0] ADDR_CLIP = 8'h46;
	localparam logic [7:0] ADDR_SMOOTH = 8'h47;
	localparam logic [7:0] ADDR_BYPASS = 8'h4a;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int BIT_SLEW_DONE = 6;
	localparam int BIT_MUTE = 7;
	localparam int VOL_W = 5;
	localparam int BIT_RIGHT_PATH = 5;
	localparam int BIT_LEFT_PATH = 4;
	localparam int RIGHT_ATT_LSB = 2;
	localparam int LEFT_ATT_LSB = 0;
	localparam int BIT_ENH_SLEW_OFF = 7;
	localparam int BIT_SLEW_OFF = 6;
	localparam int BIT_ZC_OFF = 5;
	localparam int BIT_RECV_SHORT = 1;
	localparam int BIT_RECV_TO_SPK = 0;
	localparam int LIMIT_LSB = 4;
	localparam int RELEASE_W = 4;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] RST_REG = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Charge pump thresholds, level is a fraction of the pump rail in 1/256
	localparam int LEVEL_W = 8;
	localparam int unsigned PCT_LOW_RATE = 10;
	localparam int unsigned PCT_HALF_RAIL = 25;
	localparam logic [7:0] THR_LOW_RATE = 8'(PCT_LOW_RATE * 256 / 100);
	localparam logic [7:0] THR_HALF_RAIL = 8'(PCT_HALF_RAIL * 256 / 100);

	////////////////////////////////////////////////////////////////////////////
	// Channel sequencing states
	typedef enum logic [1:0] {
		CH_OFF = 2'b00,
		CH_RAMP_UP = 2'b01,
		CH_ON = 2'b10,
		CH_RAMP_DOWN = 2'b11
	} hpv_chan_state_type;

endpackage : hpv_pkg

// ---- hdl/hpv_chan_slew.sv ----
// One headphone channel: turn-on/off ramp, slewing and zero-cross gating
module hpv_chan_slew #(
	parameter int unsigned TIMEOUT_CYC = hpv_pkg::ZC_TIMEOUT_CYC,
	parameter int unsigned STEP_CYC = hpv_pkg::SLEW_STEP_CYC
) (
	input wire logic clk_sys, // System clock
	input wire logic sys_rst, // Async reset, high
	input wire logic enable_req, // Output wanted on
	input wire logic [hpv_pkg::VOL_W-1:0] target, // Programmed volume
	input wire logic slew_on, // Stepwise slewing
	input wire logic enh_on, // Enhanced slewing
	input wire logic zc_on, // Zero-cross gating
	input wire logic zero_cross, // Synchronised crossing
	output logic [hpv_pkg::VOL_W-1:0] vol_applied, // Volume at amplifier
	output logic amp_on, // Amplifier enable
	output logic busy // Slew in progress
);
	localparam int TW = $clog2(TIMEOUT_CYC + 1);
	localparam int SW = $clog2(STEP_CYC + 1);
	localparam int VW = hpv_pkg::VOL_W;

	typedef struct packed {
		hpv_pkg::hpv_chan_state_type st;
		logic [VW-1:0] req;
		logic [VW-1:0] app;
		logic [TW-1:0] wait_cnt;
		logic [SW-1:0] tick_cnt;
		logic amp_on;
		logic busy;
	} hpv_chan_type;

	hpv_chan_type s_r;
	hpv_chan_type s_nxt;
	logic tick;
	logic enh_eff;
	logic [VW-1:0] goal;

	always_comb begin
		s_nxt = s_r;
		tick = (s_r.tick_cnt == SW'(STEP_CYC - 1));
		s_nxt.tick_cnt = tick ? '0 : SW'(s_r.tick_cnt + 1'b1);
		unique case (s_r.st)
			hpv_pkg::CH_OFF: begin
				if (enable_req) s_nxt.st = hpv_pkg::CH_RAMP_UP;
			end
			hpv_pkg::CH_RAMP_UP: begin
				if (!enable_req) s_nxt.st = hpv_pkg::CH_RAMP_DOWN;
				else if (s_r.req == target && s_r.app == target) s_nxt.st = hpv_pkg::CH_ON;
			end
			hpv_pkg::CH_ON: begin
				if (!enable_req) s_nxt.st = hpv_pkg::CH_RAMP_DOWN;
			end
			hpv_pkg::CH_RAMP_DOWN: begin
				if (enable_req) s_nxt.st = hpv_pkg::CH_RAMP_UP;
				else if (s_r.req == '0 && s_r.app == '0) s_nxt.st = hpv_pkg::CH_OFF;
			end
		endcase
		// Amplifier is on only outside OFF; app is zero whenever OFF, so it wakes muted
		s_nxt.amp_on = (s_nxt.st != hpv_pkg::CH_OFF);
		goal = (s_r.st == hpv_pkg::CH_ON || s_r.st == hpv_pkg::CH_RAMP_UP) ? target : '0;
		// Turn-off never waits on crossings between steps
		enh_eff = enh_on && (s_r.st != hpv_pkg::CH_RAMP_DOWN);
		if (s_r.req != goal) begin
			if (!slew_on) begin
				s_nxt.req = goal;
			end else if (tick && (!enh_eff || s_r.app == s_r.req)) begin
				s_nxt.req = (s_r.req < goal) ? VW'(s_r.req + 1'b1) : VW'(s_r.req - 1'b1);
			end
		end
		if (s_r.app != s_r.req) begin
			if (!zc_on || zero_cross || s_r.wait_cnt == TW'(TIMEOUT_CYC - 1)) begin
				s_nxt.app = s_r.req;
				s_nxt.wait_cnt = '0;
			end else begin
				s_nxt.wait_cnt = TW'(s_r.wait_cnt + 1'b1);
			end
		end else begin
			s_nxt.wait_cnt = '0;
		end
		s_nxt.busy = (s_nxt.req != goal) || (s_nxt.app != s_nxt.req);
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign vol_applied = s_r.app;
	assign amp_on = s_r.amp_on;
	assign busy = s_r.busy;

endmodule : hpv_chan_slew

// ---- test/hpv_monitor.sv ----
// Port-level checker for the headphone volume control block
module hpv_monitor (
	input wire logic clk_sys, // Clock
	input wire logic sys_rst, // Reset
	input wire logic [7:0] reg_addr, // Offset
	input wire logic reg_wr, // Write
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_rd, // Read
	input wire logic [7:0] reg_rdata, // Read data
	input wire logic [7:0] pump_signal_level, // Level
	input wire logic pump_dynamic_off, // Fixed mode
	input wire logic pump_force_full, // Forced rail
	input wire logic pump_fast_rate, // Rate
	input wire logic pump_full_rail, // Rail
	input wire logic [7:0] left_phone_mixer_select, // Sources
	input wire logic left_phone_path_choice, // Path
	input wire logic [3:0] left_mixer_attenuation, // Loss
	input wire logic [4:0] left_phone_volume, // Code
	input wire logic [7:0] left_phone_gain_half_db, // Gain
	input wire logic [1:0] phone_amp_on, // Amps
	input wire logic recv_amp_req, // Amp wanted
	input wire logic receiver_pin_short, // Switch
	input wire logic receiver_amp_enable, // Amp
	input wire logic zero_cross_enable, // Gating
	input wire logic slew_enable, // Slewing
	input wire logic enhanced_slew_enable // Enhanced
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////////
	// Piecewise table, half decibels
	function automatic logic [7:0] half_db(input logic [4:0] c);
		int v;
		v = int'(c);
		if (v < 7) return 8'(8 * v - 134);
		if (v < 15) return 8'(6 * v - 122);
		if (v < 22) return 8'(4 * v - 94);
		if (v < 28) return 8'(2 * v - 52);
		return 8'(v - 25);
	endfunction : half_db

	function automatic logic [3:0] loss(input logic [1:0] c);
		return (c == 2'h0) ? 4'h0 : (c == 2'h1) ? 4'h6 : (c == 2'h2) ? 4'h9 : 4'hc;
	endfunction : loss

	////////////////////////////////////////////////////////////////////////////
	// Level must sit still long enough to cross the sync chain
	sequence s_level_held;
		($stable(pump_signal_level) && !pump_dynamic_off) [*4];
	endsequence
	sequence s_write(a);
		reg_wr && reg_addr == a;
	endsequence
	sequence s_fixed_held;
		(pump_dynamic_off && $stable(pump_force_full)) [*2];
	endsequence

	property p_pump_level;
		s_level_held |-> pump_fast_rate == (pump_signal_level > 8'h19) && pump_full_rail == (pump_signal_level > 8'h40);
	endproperty
	property p_pump_fixed;
		s_fixed_held |-> pump_fast_rate && pump_full_rail == pump_force_full;
	endproperty
	property p_mix_write;
		s_write(8'h25) |=> left_phone_mixer_select == $past(reg_wdata);
	endproperty
	property p_path_write;
		s_write(8'h27) |=> left_phone_path_choice == $past(reg_wdata[4])
			##1 left_mixer_attenuation == loss($past(reg_wdata[1:0], 2));
	endproperty
	property p_smooth_read;
		reg_rd && !reg_wr && !$past(reg_wr) && !$past(sys_rst) && reg_addr == 8'h47 |=> reg_rdata[7:5] ==
			{!$past(enhanced_slew_enable), !$past(slew_enable), !$past(zero_cross_enable)};
	endproperty
	property p_recv_gate;
		!$past(sys_rst) && $stable(receiver_pin_short)
			|-> receiver_amp_enable == ($past(recv_amp_req) && !receiver_pin_short);
	endproperty
	property p_turn_on;
		$rose(phone_amp_on[0]) && slew_enable |-> left_phone_volume == 5'h00;
	endproperty
	property p_turn_off;
		$fell(phone_amp_on[0]) |-> $past(left_phone_volume) == 5'h00 && left_phone_volume == 5'h00;
	endproperty
	property p_single_step;
		slew_enable && !zero_cross_enable && $past(slew_enable) && !$past(zero_cross_enable)
			&& $changed(left_phone_volume) |-> left_phone_volume == $past(left_phone_volume) + 5'h01
			|| left_phone_volume == $past(left_phone_volume) - 5'h01;
	endproperty
	property p_gain_map;
		!$past(sys_rst) |-> left_phone_gain_half_db == half_db($past(left_phone_volume));
	endproperty

	a_pump_level: assert property (p_pump_level)
		else $error("pump mode does not follow level");
	a_pump_fixed: assert property (p_pump_fixed)
		else $error("fixed pump mode ignored");
	a_mix_write: assert property (p_mix_write)
		else $error("left sources differ from write");
	a_path_write: assert property (p_path_write)
		else $error("path or loss differs from write");
	a_smooth_read: assert property (p_smooth_read)
		else $error("smoothing read disagrees with enables");
	a_recv_gate: assert property (p_recv_gate)
		else $error("receiver amp on while pins shorted");
	a_turn_on: assert property (p_turn_on)
		else $error("amp enabled before volume muted");
	a_turn_off: assert property (p_turn_off)
		else $error("amp disabled before ramp reached mute");
	a_single_step: assert property (p_single_step)
		else $error("volume skipped a level while slewing");
	a_gain_map: assert property (p_gain_map)
		else $error("gain does not match volume code");
endmodule : hpv_monitor

// ---- test/hpv_phone_model.sv ----
// Headphone transducer side: audio crossings only while driven
module hpv_phone_model (
	input wire logic clk_sys, // Clock
	input wire logic [1:0] amp_on, // Amplifier enables
	input wire logic cross_req, // Bench asks for a crossing
	output logic [1:0] zero_cross = 2'b00 // Crossing pulses
);
	timeunit 1ns;
	timeprecision 1ns;
	// A silent transducer carries no audio, so it never crosses
	always_ff @(posedge clk_sys) begin
		zero_cross <= {2{cross_req}} & amp_on;
	end
endmodule : hpv_phone_model

// ---- test/hpv_top_test.sv ----
// Self-checking bench for the headphone volume control block
module hpv_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned ZC_CYC = 50;
	localparam int unsigned STEP_CYC = 4;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, pump_signal_level = 8'h00;
	logic reg_wr = 1'b0, reg_rd = 1'b0, pump_dynamic_off = 1'b0, pump_force_full = 1'b0;
	logic [1:0] phone_enable_req = 2'b00;
	logic recv_amp_req = 1'b0, left_spk_amp_req = 1'b0, cross_req = 1'b0;
	logic [7:0] reg_rdata, right_phone_mixer_select, left_phone_gain_half_db;
	logic [3:0] left_mixer_attenuation, right_mixer_attenuation, distortion_limit_level, distortion_release_time;
	logic [4:0] left_phone_volume;
	logic [1:0] phone_amp_on, zero_cross_in;
	logic pump_fast_rate, pump_full_rail, left_phone_mute, right_phone_mute, receiver_amp_enable;
	logic left_speaker_amp_enable, right_phone_path_choice, receiver_pin_short, receiver_to_speaker_switch;
	int bad_count = 0;
	int checked = 0;
	int n;
	// Rows: offset, write data, read-back value
	logic [23:0] regs[10] = '{24'h25a5a5, 24'h265a5a, 24'h273e3e, 24'h399f9f, 24'h3a8181, 24'h46c3c3,
		24'h47e0e0, 24'h4a0303, 24'h307700, 24'h00ff00};
	// Rows: level, fixed, forced, fast, full
	logic [11:0] pump[6] = '{12'h190, 12'h1a2, 12'h402, 12'h413, 12'h00f, 12'h50a};
	logic [7:0] att[4] = '{8'h00, 8'h06, 8'h09, 8'h0c};

	always #25 clk_sys = ~clk_sys;

	hpv_top #(.ZC_TIMEOUT_CYC(ZC_CYC), .SLEW_STEP_CYC(STEP_CYC)) DUT (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pump_signal_level(pump_signal_level),
		.pump_dynamic_off(pump_dynamic_off), .pump_force_full(pump_force_full), .zero_cross_in(zero_cross_in),
		.phone_enable_req(phone_enable_req), .recv_amp_req(recv_amp_req), .left_spk_amp_req(left_spk_amp_req),
		.pump_fast_rate(pump_fast_rate), .pump_full_rail(pump_full_rail), .left_phone_mixer_select(),
		.right_phone_mixer_select(right_phone_mixer_select), .left_phone_path_choice(),
		.right_phone_path_choice(right_phone_path_choice), .left_mixer_attenuation(left_mixer_attenuation),
		.right_mixer_attenuation(right_mixer_attenuation), .left_phone_mute(left_phone_mute),
		.right_phone_mute(right_phone_mute), .left_phone_volume(left_phone_volume), .right_phone_volume(),
		.left_phone_gain_half_db(left_phone_gain_half_db), .right_phone_gain_half_db(),
		.phone_amp_on(phone_amp_on), .receiver_pin_short(receiver_pin_short),
		.receiver_to_speaker_switch(receiver_to_speaker_switch),
		.receiver_amp_enable(receiver_amp_enable), .left_speaker_amp_enable(left_speaker_amp_enable),
		.zero_cross_enable(), .slew_enable(), .enhanced_slew_enable(),
		.distortion_limit_level(distortion_limit_level), .distortion_release_time(distortion_release_time)
	);

	hpv_phone_model phones (.clk_sys(clk_sys), .amp_on(phone_amp_on), .cross_req(cross_req),
		.zero_cross(zero_cross_in));

	////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask : rd

	// Counts cycles into n; gives up after lim
	task automatic wait_vol(input logic [4:0] v, input int lim);
		for (n = 0; left_phone_volume !== v; n++) begin
			if (n > lim) begin
				$display("[FAIL] volume expected %h seen %h", v, left_phone_volume);
				bad_count++;
				report_and_stop();
			end
			@(negedge clk_sys);
		end
	endtask : wait_vol

	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] d;
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		foreach (regs[i]) begin
			rd(regs[i][23:16], d);
			chk("reset value", 8'h00, d);
			wr(regs[i][23:16], regs[i][15:8]);
			rd(regs[i][23:16], d);
			chk("read back", regs[i][7:0], d);
		end
		chk("right sources", 8'h5a, right_phone_mixer_select);
		chk("right mute", 8'h01, 8'(right_phone_mute));
		chk("left mute", 8'h01, 8'(left_phone_mute));
		chk("release", 8'h03, 8'(distortion_release_time));
		chk("limit", 8'h0c, 8'(distortion_limit_level));
		chk("right path", 8'h01, 8'(right_phone_path_choice));
		chk("bypass switches", 8'h03, 8'({receiver_pin_short, receiver_to_speaker_switch}));
		foreach (pump[i]) begin
			@(posedge clk_sys);
			{pump_signal_level, pump_dynamic_off, pump_force_full} <= pump[i][11:2];
			repeat (6) @(negedge clk_sys);
			chk("pump rate", 8'(pump[i][1]), 8'(pump_fast_rate));
			chk("pump rail", 8'(pump[i][0]), 8'(pump_full_rail));
		end
		for (int i = 0; i < 4; i++) begin
			wr(8'h27, 8'(5 * i));
			repeat (2) @(negedge clk_sys);
			chk("left loss", att[i], 8'(left_mixer_attenuation));
			chk("right loss", att[i], 8'(right_mixer_attenuation));
		end
		@(posedge clk_sys);
		recv_amp_req <= 1'b1;
		left_spk_amp_req <= 1'b1;
		for (int v = 0; v < 4; v++) begin
			wr(8'h4a, 8'(v));
			repeat (3) @(negedge clk_sys);
			chk("receiver amp", 8'(!v[1]), 8'(receiver_amp_enable));
			chk("speaker amp", 8'(!v[0]), 8'(left_speaker_amp_enable));
		end
		// Slewed turn-on, status flag, then plain and slewed changes
		wr(8'h47, 8'h20);
		wr(8'h39, 8'h03);
		rd(8'h00, d);
		@(posedge clk_sys);
		phone_enable_req <= 2'b01;
		wait_vol(5'h03, 40);
		repeat (4) @(negedge clk_sys);
		chk("gain", 8'h92, left_phone_gain_half_db);
		rd(8'h00, d);
		chk("status done", 8'h40, d);
		rd(8'h00, d);
		chk("status cleared", 8'h00, d);
		wr(8'h47, 8'h60);
		wr(8'h39, 8'h07);
		wait_vol(5'h07, 4);
		repeat (4) @(negedge clk_sys);
		chk("gain", 8'hb0, left_phone_gain_half_db);
		wr(8'h47, 8'h20);
		wr(8'h39, 8'h03);
		wait_vol(5'h03, 40);
		chk("slew time", 8'h01, 8'(n >= 10));
		// Gated steps: timeout first, then a real crossing
		wr(8'h47, 8'h00);
		wr(8'h39, 8'h05);
		wait_vol(5'h04, ZC_CYC + 20);
		chk("timeout wait", 8'h01, 8'(n >= ZC_CYC));
		repeat (8) @(posedge clk_sys);
		cross_req <= 1'b1;
		@(posedge clk_sys);
		cross_req <= 1'b0;
		wait_vol(5'h05, 10);
		// Turn-off must not wait a timeout per step
		@(posedge clk_sys);
		phone_enable_req <= 2'b00;
		for (n = 0; phone_amp_on[0] !== 1'b0; n++) begin
			if (n > 2 * ZC_CYC) begin
				$display("[FAIL] amp on after %0d cycles", n);
				bad_count++;
				report_and_stop();
			end
			@(negedge clk_sys);
		end
		chk("volume at turn-off", 8'h00, 8'(left_phone_volume));
		report_and_stop();
	end
endmodule : hpv_top_test

bind hpv_top hpv_monitor u_mon (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pump_signal_level(pump_signal_level),
	.pump_dynamic_off(pump_dynamic_off), .pump_force_full(pump_force_full), .pump_fast_rate(pump_fast_rate),
	.pump_full_rail(pump_full_rail), .left_phone_mixer_select(left_phone_mixer_select),
	.left_phone_path_choice(left_phone_path_choice), .left_mixer_attenuation(left_mixer_attenuation),
	.left_phone_volume(left_phone_volume), .left_phone_gain_half_db(left_phone_gain_half_db),
	.phone_amp_on(phone_amp_on), .recv_amp_req(recv_amp_req), .receiver_pin_short(receiver_pin_short),
	.receiver_amp_enable(receiver_amp_enable), .zero_cross_enable(zero_cross_enable),
	.slew_enable(slew_enable), .enhanced_slew_enable(enhanced_slew_enable)
);
